//--- hw/cse_cache_slice_event_selector.v
// event decode and per-cycle increment for one cache slice monitor counter
//
// Decided for this implementation: the plain strobed port and the placing of the registers.
`timescale 1ns/1ps
`include "cse_defines.vh"

module cse_cache_slice_event_selector (
  input  wire        clk_sys,          // uncore clock, 100 MHz
  input  wire        arst_n,           // async reset, active low
  // register port
  input  wire [3:0]  regAddr,          // register index
  input  wire [31:0] regWrData,        // write data
  input  wire        regWrEn,          // write strobe
  input  wire        regRdEn,          // read strobe
  output reg  [31:0] regRdData,        // read data, cycle after strobe
  // far side levels and strobes, sampled every edge
  input  wire [7:0]  rejectCauseSetTwo,// reject causes, bit n per cause
  input  wire [3:0]  probeQueueFill,   // valid probe queue entries
  input  wire [4:0]  respQueueFill,    // response queue entries
  input  wire [4:0]  missFileFill,     // occupied miss file entries
  input  wire [3:0]  snoopRespFill,    // snoop response buffer fill
  input  wire [3:0]  rdwrFill,         // request buffer fill
  input  wire [3:0]  victimQueueFill,  // victim queue fill
  input  wire [2:0]  sliceToCoreSink,  // beats: snoop, ack, data
  input  wire [2:0]  coreToSliceSink,  // beats: req, snp rsp, wb data
  input  wire [2:0]  sysifToSliceSink, // beats: snoop, compl, fill
  input  wire        sysifToCoreSink,  // data ring beat to core
  input  wire [7:0]  snoopHit,         // rd M/E/S/F, own M/E/S/F
  input  wire [1:0]  snoopLookup,      // rd to shared, own to invalid
  input  wire [7:0]  egressStarved,    // starved egress queues
  input  wire        probeQueueWrite,  // probe written to probe queue
  input  wire        respQueueWrite,   // request written to resp queue
  input  wire        missFileAlloc,    // miss file entry allocated
  input  wire        snoopRespPass,    // snoop response passed buffer
  input  wire        rdwrPass,         // request passed request buffer
  input  wire        victimEnter,      // victim entered victim queue
  // selection outputs, registered
  output reg  [4:0]  incValue,         // increment for the counter
  output reg  [7:0]  evCode,           // selected event code
  output reg  [7:0]  evMask            // selected sub-event mask
);

  // ==========================================================
  // reset release
  reg rstMeta_q;
  reg rstSync_q;
  // two flops so release is clean against clk_sys
  always @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      rstMeta_q <= 1'b0;
      rstSync_q <= 1'b0;
    end else begin
      rstMeta_q <= 1'b1;
      rstSync_q <= rstMeta_q;
    end
  end
  // the state block also holds reset on the released copy; the read port resets on arst_n alone
  wire rstN = rstSync_q;

  // ==========================================================
  // helpers
  // count of set bits in a byte
  function [4:0] popCount8;
    input [7:0] v;
    integer i;
    begin
      popCount8 = 5'd0;
      for (i = 0; i < 8; i = i + 1)
        popCount8 = popCount8 + {4'd0, v[i]};
    end
  endfunction

  // clip a sum to the event limit
  function [4:0] clipTo;
    input [5:0] v;
    input [4:0] lim;
    begin
      if (v > {1'b0, lim})
        clipTo = lim;
      else
        clipTo = v[4:0];
    end
  endfunction

  // ==========================================================
  // registers
  // index 0: event select, code in bits 7:0, mask in bits 15:8
  // index 1: last increment, read only
  // index 2: local count bits 31:0, read only
  // index 3: local count bits 47:32, read only
  // writing index 0 clears the local count; other writes are dropped
  reg [15:0] evSel_q;
  reg [47:0] count_q;
  reg [4:0]  lastInc_q;
  reg [4:0]  inc_d;

  wire [7:0] selCode = evSel_q[`CSE_EVSEL_CODE_LSB +: 8];
  wire [7:0] selMask = evSel_q[`CSE_EVSEL_MASK_LSB +: 8];

  // ==========================================================
  // event decode
  // three steps: gather the strobes or the level of the selected
  // code, keep only mask bits that name a sub-event, then sum and
  // clip to the code's limit; one adder and one clipper serve all
  // codes, which costs a little depth but keeps the limits together

  // mask bits that name a sub-event of each code
  function [7:0] legalMask;
    input [7:0] code;
    begin
      case (code)
        // bit 0 belongs to the first reject set, never counted here
        `CSE_EV_REJECT_SET_TWO:
          legalMask = 8'hFE;
        `CSE_EV_SLICE_TO_CORE:
          legalMask = 8'h07;
        `CSE_EV_CORE_TO_SLICE:
          legalMask = 8'h07;
        `CSE_EV_SYSIF_TO_SLICE:
          legalMask = 8'h07;
        `CSE_EV_SNOOP_HITS:
          legalMask = 8'hFF;
        `CSE_EV_SNOOP_LOOKUPS:
          legalMask = 8'h03;
        `CSE_EV_STARVED_EGRESS:
          legalMask = 8'hFF;
        default:
          legalMask = 8'h00;
      endcase
    end
  endfunction

  // codes with a single strobe and no sub-events ignore the mask
  function isSingle;
    input [7:0] code;
    begin
      case (code)
        `CSE_EV_SYSIF_TO_CORE,
        `CSE_EV_PROBE_ENTRIES,
        `CSE_EV_RESP_ENTRIES,
        `CSE_EV_MISS_ALLOCS,
        `CSE_EV_SNPRESP_PASSES,
        `CSE_EV_RDWR_PASSES,
        `CSE_EV_VICTIM_ENTRIES:
          isSingle = 1'b1;
        default:
          isSingle = 1'b0;
      endcase
    end
  endfunction

  // occupancy codes add a queue level rather than counting strobes
  function isFill;
    input [7:0] code;
    begin
      case (code)
        `CSE_EV_PROBE_FILL,
        `CSE_EV_RESP_FILL,
        `CSE_EV_MISS_FILL,
        `CSE_EV_SNPRESP_FILL,
        `CSE_EV_RDWR_FILL,
        `CSE_EV_VICTIM_FILL:
          isFill = 1'b1;
        default:
          isFill = 1'b0;
      endcase
    end
  endfunction

  // largest increment a code may give in one cycle; an unknown code
  // gets zero, so a stray selection never moves the counter
  function [4:0] evLimit;
    input [7:0] code;
    begin
      case (code)
        `CSE_EV_REJECT_SET_TWO:
          evLimit = `CSE_MAX_ONE;
        `CSE_EV_PROBE_FILL:
          evLimit = `CSE_MAX_PROBE_FILL;
        `CSE_EV_RESP_FILL:
          evLimit = `CSE_MAX_RESP_FILL;
        `CSE_EV_MISS_FILL:
          evLimit = `CSE_MAX_MISS_FILL;
        `CSE_EV_SNPRESP_FILL:
          evLimit = `CSE_MAX_SNPRESP_FILL;
        `CSE_EV_RDWR_FILL:
          evLimit = `CSE_MAX_RDWR_FILL;
        `CSE_EV_VICTIM_FILL:
          evLimit = `CSE_MAX_VICTIM_FILL;
        `CSE_EV_SLICE_TO_CORE:
          evLimit = `CSE_MAX_SINK3;
        `CSE_EV_CORE_TO_SLICE:
          evLimit = `CSE_MAX_SINK3;
        `CSE_EV_SYSIF_TO_SLICE:
          evLimit = `CSE_MAX_SINK3;
        `CSE_EV_SYSIF_TO_CORE:
          evLimit = `CSE_MAX_ONE;
        `CSE_EV_SNOOP_HITS:
          evLimit = `CSE_MAX_ONE;
        `CSE_EV_SNOOP_LOOKUPS:
          evLimit = `CSE_MAX_ONE;
        `CSE_EV_STARVED_EGRESS:
          evLimit = `CSE_MAX_STARVED;
        `CSE_EV_PROBE_ENTRIES:
          evLimit = `CSE_MAX_ONE;
        `CSE_EV_RESP_ENTRIES:
          evLimit = `CSE_MAX_ONE;
        `CSE_EV_MISS_ALLOCS:
          evLimit = `CSE_MAX_ONE;
        `CSE_EV_SNPRESP_PASSES:
          evLimit = `CSE_MAX_ONE;
        `CSE_EV_RDWR_PASSES:
          evLimit = `CSE_MAX_ONE;
        `CSE_EV_VICTIM_ENTRIES:
          evLimit = `CSE_MAX_ONE;
        default:
          evLimit = 5'h00;
      endcase
    end
  endfunction

  // strobe vector of the selected code, one bit per sub-event
  reg [7:0] evBits;
  always @* begin
    evBits = 8'h00;
    case (selCode)
      `CSE_EV_REJECT_SET_TWO:
        evBits = rejectCauseSetTwo;
      // sink strobes come once per 32-byte beat, a line gives two
      `CSE_EV_SLICE_TO_CORE:
        evBits = {5'h00, sliceToCoreSink};
      `CSE_EV_CORE_TO_SLICE:
        evBits = {5'h00, coreToSliceSink};
      `CSE_EV_SYSIF_TO_SLICE:
        evBits = {5'h00, sysifToSliceSink};
      `CSE_EV_SYSIF_TO_CORE:
        evBits = {7'h00, sysifToCoreSink};
      `CSE_EV_SNOOP_HITS:
        evBits = snoopHit;
      `CSE_EV_SNOOP_LOOKUPS:
        evBits = {6'h00, snoopLookup};
      `CSE_EV_STARVED_EGRESS:
        evBits = egressStarved;
      `CSE_EV_PROBE_ENTRIES:
        evBits = {7'h00, probeQueueWrite};
      `CSE_EV_RESP_ENTRIES:
        evBits = {7'h00, respQueueWrite};
      `CSE_EV_MISS_ALLOCS:
        evBits = {7'h00, missFileAlloc};
      `CSE_EV_SNPRESP_PASSES:
        evBits = {7'h00, snoopRespPass};
      `CSE_EV_RDWR_PASSES:
        evBits = {7'h00, rdwrPass};
      // victims that later skip writeback still count here
      `CSE_EV_VICTIM_ENTRIES:
        evBits = {7'h00, victimEnter};
      default:
        evBits = 8'h00;
    endcase
  end

  // queue level of the selected occupancy code
  reg [4:0] fillLvl;
  always @* begin
    fillLvl = 5'h00;
    case (selCode)
      `CSE_EV_PROBE_FILL:
        fillLvl = {1'b0, probeQueueFill};
      `CSE_EV_RESP_FILL:
        fillLvl = respQueueFill;
      `CSE_EV_MISS_FILL:
        fillLvl = missFileFill;
      `CSE_EV_SNPRESP_FILL:
        fillLvl = {1'b0, snoopRespFill};
      `CSE_EV_RDWR_FILL:
        fillLvl = {1'b0, rdwrFill};
      `CSE_EV_VICTIM_FILL:
        fillLvl = {1'b0, victimQueueFill};
      default:
        fillLvl = 5'h00;
    endcase
  end

  // keep legal mask bits, count them or take the level, then clip;
  // overlapping sub-events add up but never pass the code's limit
  wire [7:0] keepBits;
  wire [7:0] hotBits;
  wire [5:0] rawSum;
  assign keepBits = isSingle(selCode) ? 8'h01
                                      : (legalMask(selCode) & selMask);
  assign hotBits  = evBits & keepBits;
  assign rawSum   = isFill(selCode) ? {1'b0, fillLvl}
                                    : {1'b0, popCount8(hotBits)};
  always @* begin
    inc_d = clipTo(rawSum, evLimit(selCode));
  end

  // ==========================================================
  // state: selection, increment output and a local counter
  // the local counter lets software check the selector alone;
  // overflow handling belongs to the counter outside
  always @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      evSel_q   <= `CSE_EVSEL_RESET;
      count_q   <= 48'd0;
      lastInc_q <= 5'd0;
      incValue  <= 5'd0;
      evCode    <= 8'h00;
      evMask    <= 8'h00;
    end else if (!rstN) begin
      evSel_q   <= `CSE_EVSEL_RESET;
      count_q   <= 48'd0;
      lastInc_q <= 5'd0;
      incValue  <= 5'd0;
      evCode    <= 8'h00;
      evMask    <= 8'h00;
    end else begin
      incValue  <= inc_d;
      lastInc_q <= inc_d;
      evCode    <= selCode;
      evMask    <= selMask;
      if (regWrEn && regAddr == `CSE_REG_EVSEL) begin
        evSel_q <= regWrData[15:0];
        count_q <= 48'd0;  // new selection starts a fresh count
      end else begin
        count_q <= count_q + {43'd0, inc_d};
      end
    end
  end

  // ==========================================================
  // read port, data stands only in the cycle after the strobe
  // unmapped indices read as zero
  always @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      regRdData <= 32'h00000000;
    end else if (regRdEn) begin
      case (regAddr)
        `CSE_REG_EVSEL:    regRdData <= {16'h0000, evSel_q};
        `CSE_REG_LAST_INC: regRdData <= {27'd0, lastInc_q};
        `CSE_REG_COUNT_LO: regRdData <= count_q[31:0];
        `CSE_REG_COUNT_HI: regRdData <= {16'h0000, count_q[47:32]};
        default:           regRdData <= 32'h00000000;
      endcase
    end else begin
      regRdData <= 32'h00000000;
    end
  end

endmodule // cse_cache_slice_event_selector

//--- hw/cse_defines.vh
// event codes, mask layout and per-event increment limits of the selector
`ifndef CSE_DEFINES_VH
`define CSE_DEFINES_VH

// event codes
`define CSE_EV_REJECT_SET_TWO    8'h12
`define CSE_EV_PROBE_FILL        8'h1A
`define CSE_EV_RESP_FILL         8'h18
`define CSE_EV_MISS_FILL         8'h1E
`define CSE_EV_SNPRESP_FILL      8'h22
`define CSE_EV_RDWR_FILL         8'h20
`define CSE_EV_VICTIM_FILL       8'h1C
`define CSE_EV_SLICE_TO_CORE     8'h06
`define CSE_EV_CORE_TO_SLICE     8'h05
`define CSE_EV_SYSIF_TO_SLICE    8'h07
`define CSE_EV_SYSIF_TO_CORE     8'h08
`define CSE_EV_SNOOP_HITS        8'h28
`define CSE_EV_SNOOP_LOOKUPS     8'h27
`define CSE_EV_STARVED_EGRESS    8'h0B
`define CSE_EV_PROBE_ENTRIES     8'h1B
`define CSE_EV_RESP_ENTRIES      8'h19
`define CSE_EV_MISS_ALLOCS       8'h1F
`define CSE_EV_SNPRESP_PASSES    8'h23
`define CSE_EV_RDWR_PASSES       8'h21
`define CSE_EV_VICTIM_ENTRIES    8'h1D

// per-cycle increment limits
`define CSE_MAX_PROBE_FILL       5'd8
`define CSE_MAX_RESP_FILL        5'd24
`define CSE_MAX_MISS_FILL        5'd16
`define CSE_MAX_SNPRESP_FILL     5'd8
`define CSE_MAX_RDWR_FILL        5'd12
`define CSE_MAX_VICTIM_FILL      5'd8
`define CSE_MAX_SINK3            5'd3
`define CSE_MAX_ONE              5'd1
`define CSE_MAX_STARVED          5'd8

// mask field of the reject-cause set, bit 0 is not part of set two
`define CSE_REJ_FIRST_BIT        1
`define CSE_REJ_LAST_BIT         7

// register map of the plain port
`define CSE_REG_EVSEL            4'h0
`define CSE_REG_LAST_INC         4'h1
`define CSE_REG_COUNT_LO         4'h2
`define CSE_REG_COUNT_HI         4'h3
`define CSE_EVSEL_RESET          16'h0000
`define CSE_EVSEL_CODE_LSB       0
`define CSE_EVSEL_MASK_LSB       8

`endif

//--- dv/cse_selector_props.sv
// assertions on the event selector ports
`timescale 1ns/1ps
module cse_selector_props (
  input wire       clk_sys,          // clock
  input wire       arst_n,           // async reset
  input wire [7:0] evCode,           // code
  input wire [7:0] evMask,           // mask
  input wire [4:0] incValue,         // increment
  input wire [3:0] probeQueueFill,   // probe fill
  input wire [4:0] missFileFill,     // miss fill
  input wire [2:0] coreToSliceSink,  // core beats
  input wire [2:0] sysifToSliceSink, // sysif beats
  input wire       sysifToCoreSink,  // data beat
  input wire [7:0] snoopHit,         // hits
  input wire [7:0] egressStarved,    // starved
  input wire [7:0] rejectCauseSetTwo // rejects
);
  wire [15:0] sel = {evMask, evCode};
  // ==========================================================
  // increment checks; the selection must hold over the sample
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!arst_n);
  probe_fill_a: assert property (
    evCode == 8'h1A && $stable(sel) |-> incValue ==
    (($past(probeQueueFill) > 8) ? 5'd8 : $past(probeQueueFill)))
    else $error("probe fill increment wrong");
  miss_fill_a: assert property (
    evCode == 8'h1E && $stable(sel) |-> incValue ==
    (($past(missFileFill) > 16) ? 5'd16 : $past(missFileFill)))
    else $error("miss fill increment wrong");
  core_sink_a: assert property (
    evCode == 8'h05 && $stable(sel) |->
    incValue == $countones($past(coreToSliceSink) & evMask[2:0]))
    else $error("core sink increment wrong");
  sysif_sink_a: assert property (
    evCode == 8'h07 && $stable(sel) |->
    incValue == $countones($past(sysifToSliceSink) & evMask[2:0]))
    else $error("sysif sink increment wrong");
  data_beat_a: assert property (
    evCode == 8'h08 && $stable(sel) |-> incValue == $past(sysifToCoreSink))
    else $error("data beat increment wrong");
  snoop_hit_a: assert property (
    evCode == 8'h28 && $stable(sel) |->
    incValue == |($past(snoopHit) & evMask))
    else $error("snoop hit increment wrong");
  starved_egress_a: assert property (
    evCode == 8'h0B && $stable(sel) |->
    incValue == $countones($past(egressStarved) & evMask))
    else $error("starved increment wrong");
  reject_cause_a: assert property (
    evCode == 8'h12 && $stable(sel) |->
    incValue == |($past(rejectCauseSetTwo) & evMask & 8'hFE))
    else $error("reject increment wrong");
  inc_limit_a: assert property (incValue <= 24)
    else $error("increment above largest limit");
endmodule // cse_selector_props

//--- dv/cse_far_side_model.sv
// far side: slice queues, ring stops and miss tracker
`timescale 1ns/1ps
module cse_far_side_model (
  input  wire [7:0] act,               // pattern
  input  wire [4:0] lvl,               // fill level
  output wire [7:0] rejectCauseSetTwo, // rejects
  output wire [3:0] probeQueueFill,    // fill
  output wire [4:0] respQueueFill,     // fill
  output wire [4:0] missFileFill,      // fill
  output wire [3:0] snoopRespFill,     // fill
  output wire [3:0] rdwrFill,          // fill
  output wire [3:0] victimQueueFill,   // fill
  output wire [2:0] sliceToCoreSink,   // beats
  output wire [2:0] coreToSliceSink,   // beats
  output wire [2:0] sysifToSliceSink,  // beats
  output wire       sysifToCoreSink,   // beat
  output wire [7:0] snoopHit,          // hits
  output wire [1:0] snoopLookup,       // lookups
  output wire [7:0] egressStarved,     // starved
  output wire       probeQueueWrite,   // strobe
  output wire       respQueueWrite,    // strobe
  output wire       missFileAlloc,     // strobe
  output wire       snoopRespPass,     // strobe
  output wire       rdwrPass,          // strobe
  output wire       victimEnter        // strobe
);
  // each single strobe has its own bit, so a swapped source shows
  assign {rejectCauseSetTwo, snoopHit, egressStarved} = {3{act}};
  assign {sliceToCoreSink, coreToSliceSink} = {2{act[2:0]}};
  assign sysifToSliceSink = act[2:0];
  assign snoopLookup = act[1:0];
  assign {sysifToCoreSink, victimEnter, rdwrPass, snoopRespPass} = act[7:4];
  assign {missFileAlloc, respQueueWrite, probeQueueWrite} = act[3:1];
  // narrow queues cut the level, as no queue exceeds its depth
  assign {respQueueFill, missFileFill} = {2{lvl}};
  assign {probeQueueFill, snoopRespFill} = {2{lvl[3:0]}};
  assign {rdwrFill, victimQueueFill} = {2{lvl[3:0]}};
endmodule // cse_far_side_model

//--- dv/cse_cache_slice_event_selector_tb.sv
// self-checking bench for the cache slice event selector
`timescale 1ns/1ps
module cse_cache_slice_event_selector_tb;
  logic        clk_sys = 1'b0, arst_n = 1'b0;
  logic        regWrEn = 1'b0, regRdEn = 1'b0;
  logic [3:0]  regAddr = 4'h0;
  logic [31:0] regWrData = 32'h0;
  logic [7:0]  act = 8'h00;
  logic [4:0]  lvl = 5'h00;
  wire  [31:0] regRdData;
  wire  [7:0]  rejectCauseSetTwo, snoopHit, egressStarved, evCode, evMask;
  wire  [4:0]  respQueueFill, missFileFill, incValue;
  wire  [3:0]  probeQueueFill, snoopRespFill, rdwrFill, victimQueueFill;
  wire  [2:0]  sliceToCoreSink, coreToSliceSink, sysifToSliceSink;
  wire  [1:0]  snoopLookup;
  wire         sysifToCoreSink, probeQueueWrite, respQueueWrite;
  wire         missFileAlloc, snoopRespPass, rdwrPass, victimEnter;
  int          n_mismatch = 0, check_count = 0, cycles = 0;
  localparam logic [7:0] single [1:7] =
    '{8'h1B, 8'h19, 8'h1F, 8'h23, 8'h21, 8'h1D, 8'h08};
  cse_cache_slice_event_selector uut (.*);
  cse_far_side_model far (.*);
  // ==========================================================
  // clock and hang guard
  always #5 clk_sys = ~clk_sys;
  always @(posedge clk_sys) begin
    cycles <= cycles + 1;
    if (cycles == 2000) begin
      n_mismatch++;
      conclude();
    end
  end
  // ==========================================================
  // reference increment for a selection and a far-side pattern
  function automatic [4:0] expInc(input [7:0] c, m, a, input [4:0] l);
    expInc = 5'h00;
    case (c)
      8'h12: expInc = |(a & m & 8'hFE);
      8'h28: expInc = |(a & m);
      8'h27: expInc = |(a & m & 8'h03);
      8'h05, 8'h06, 8'h07: expInc = $countones(a & m & 8'h07);
      8'h0B: expInc = $countones(a & m);
      8'h1A, 8'h1C, 8'h22: expInc = (l[3:0] > 8) ? 5'd8 : l[3:0];
      8'h20: expInc = (l[3:0] > 12) ? 5'd12 : l[3:0];
      8'h18: expInc = (l > 24) ? 5'd24 : l;
      8'h1E: expInc = (l > 16) ? 5'd16 : l;
      default: for (int i = 1; i < 8; i++) if (c == single[i]) expInc = a[i];
    endcase
  endfunction
  task automatic check(input [31:0] seen, exp);
    check_count++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic wr(input [3:0] a, input [31:0] d);
    regAddr <= a;
    regWrData <= d;
    regWrEn <= 1'b1;
    @(posedge clk_sys);
    regWrEn <= 1'b0;
  endtask
  task automatic rd(input [3:0] a, input [31:0] e);
    regAddr <= a;
    regRdEn <= 1'b1;
    @(posedge clk_sys);
    regRdEn <= 1'b0;
    #1 check(regRdData, e);
  endtask
  // select, hold the pattern one sample, judge the increment
  task automatic evt(input [7:0] c, m, a, input [4:0] l);
    wr(4'h0, {16'h0000, m, c});
    act <= a;
    lvl <= l;
    @(posedge clk_sys);
    #1 check(incValue, expInc(c, m, a, l));
    check({24'h0, evCode}, {24'h0, c});
    check({24'h0, evMask}, {24'h0, m});
    @(posedge clk_sys);
  endtask
  // ==========================================================
  // scenarios
  task automatic t_regs;
    rd(4'h0, 32'h0);
    wr(4'h0, 32'h0000_0F0B);
    rd(4'h0, 32'h0000_0F0B);
    wr(4'h2, 32'hFFFF_FFFF); // count is read-only
    rd(4'h2, 32'h0);
    rd(4'hF, 32'h0);         // unmapped index
  endtask
  task automatic t_beats;
    wr(4'h0, 32'h0000_0407); // fill beats; clears the count
    act <= 8'h04;
    repeat (2) @(posedge clk_sys); // one line is two beats
    act <= 8'h00;
    repeat (3) @(posedge clk_sys);
    rd(4'h2, 32'h2);
    rd(4'h3, 32'h0);
  endtask
  task automatic t_fill;
    evt(8'h1A, 8'h00, 8'h00, 5'h1F);
    evt(8'h18, 8'h00, 8'h00, 5'h1F);
    evt(8'h18, 8'h00, 8'h00, 5'h17);
    evt(8'h1E, 8'h00, 8'h00, 5'h11);
    evt(8'h1E, 8'h00, 8'h00, 5'h10);
    evt(8'h22, 8'h00, 8'h00, 5'h1F);
    evt(8'h20, 8'h00, 8'h00, 5'h0D);
    evt(8'h1C, 8'h00, 8'h00, 5'h05);
    rd(4'h1, 32'h5);                 // last increment holds the level
  endtask
  task automatic t_mask;
    evt(8'h12, 8'hFF, 8'h01, 5'h00);
    evt(8'h12, 8'hFE, 8'hFE, 5'h00);
    evt(8'h06, 8'h07, 8'h05, 5'h00);
    evt(8'h06, 8'h00, 8'h07, 5'h00);
    evt(8'h05, 8'h07, 8'h07, 5'h00);
    evt(8'h07, 8'h02, 8'h03, 5'h00);
    evt(8'h28, 8'hF0, 8'h1F, 5'h00);
    evt(8'h27, 8'h01, 8'h02, 5'h00);
    evt(8'h27, 8'h02, 8'h02, 5'h00);
    evt(8'h0B, 8'hFF, 8'hFF, 5'h00);
    evt(8'h0B, 8'h18, 8'h1C, 5'h00);
    evt(8'h00, 8'hFF, 8'hFF, 5'h1F); // unknown code adds nothing
  endtask
  task automatic t_single;
    for (int i = 1; i < 8; i++) begin
      evt(single[i], 8'h00, 8'h01 << i, 5'h00);
      evt(single[i], 8'hFF, ~(8'h01 << i), 5'h1F);
    end
  endtask
  task automatic conclude;
    if (n_mismatch == 0 && check_count > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  initial begin
    repeat (12) @(posedge clk_sys);
    arst_n <= 1'b1;
    repeat (3) @(posedge clk_sys);
    t_regs();
    t_beats();
    t_fill();
    t_mask();
    t_single();
    conclude();
  end
endmodule // cse_cache_slice_event_selector_tb
bind cse_cache_slice_event_selector cse_selector_props u_props (.*);
